/* File: dv/ipcb_bank_test.sv */
// Self-checking bench for the interrupt priority bank.
// Assumes ipcb_pkg and ipcb_bank are compiled first; bench drives all input ports.
`timescale 1ns/1ps

module ipcb_bank_test;

    logic                 clk;
    logic                 nrst;
    logic [2:0]           addr;
    logic [15:0]          wdata;
    logic                 wr;
    logic                 rd;
    logic [15:0]          rdata;
    logic [9:0]           src_req;
    ipcb_pkg::ipcb_prio_s prio;
    logic [9:0]           req_out;
    logic [2:0]           top_level;
    logic [15:0]          model [8];
    logic [15:0]          d;
    int                   miscompares;
    int                   checks_done;
    int                   cycles;

    ipcb_bank dut (.clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata), .src_req(src_req), .prio(prio),
        .req_out(req_out), .top_level(top_level));

    initial clk = 1'b0;
    always #5 clk = ~clk;

    // ****************************************************************
    // Expectations
    // ****************************************************************
    function automatic logic [15:0] field_mask(input int a);
        case (a)
            0: return 16'h0770;
            1: return 16'h0070;
            2: return 16'h0070;
            3: return 16'h0770;
            4: return 16'h0700;
            5: return 16'h7770;
            default: return 16'h0000;
        endcase
    endfunction : field_mask

    // Struct order: capture four first, first UART error last
    function logic [29:0] exp_prio();
        return {model[0][10:8], model[0][6:4], model[1][6:4], model[2][6:4],
            model[3][10:8], model[3][6:4], model[4][10:8], model[5][14:12],
            model[5][10:8], model[5][6:4]};
    endfunction : exp_prio

    function logic [12:0] exp_gate(input logic [9:0] v);
        logic [29:0] p;
        logic [9:0]  g;
        logic [2:0]  t;
        p = exp_prio();
        g = 10'h000;
        t = 3'h0;
        for (int i = 0; i < 10; i++) begin
            g[i] = v[i] && (p[3*i +: 3] != 3'h0);
            if (g[i] && p[3*i +: 3] > t) begin
                t = p[3*i +: 3];
            end
        end
        return {g, t};
    endfunction : exp_gate

    // ****************************************************************
    // Compares and bus tasks
    // ****************************************************************
    task automatic check_rdata(input string what, input logic [15:0] e);
        checks_done++;
        if (rdata !== e) begin
            miscompares++;
            $display("FAIL %s expected %h seen %h", what, e, rdata);
        end
    endtask : check_rdata

    task automatic check_prio(input logic [29:0] e);
        checks_done++;
        if (prio !== e) begin
            miscompares++;
            $display("FAIL prio expected %h seen %h", e, prio);
        end
    endtask : check_prio

    task automatic check_gate(input logic [12:0] e);
        checks_done++;
        if ({req_out, top_level} !== e) begin
            miscompares++;
            $display("FAIL gate expected %h seen %h", e,
                {req_out, top_level});
        end
    endtask : check_gate

    task automatic wr_reg(input logic [2:0] a, input logic [15:0] v);
        @(posedge clk);
        addr  <= a;
        wdata <= v;
        wr    <= 1'b1;
        rd    <= 1'b0;
    endtask : wr_reg

    task automatic rd_reg(input logic [2:0] a, input logic [15:0] e);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        wr   <= 1'b0;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        check_rdata("rdata", e);
        @(posedge clk);
        #1;
        check_rdata("rdata idle", 16'h0000);
    endtask : rd_reg

    task automatic check_all();
        for (int a = 0; a < 8; a++) begin
            rd_reg(a[2:0], model[a]);
        end
        check_prio(exp_prio());
    endtask : check_all

    task automatic gate_test(input logic [9:0] v);
        @(posedge clk);
        src_req <= v;
        @(posedge clk);
        #1;
        check_gate(exp_gate(v));
    endtask : gate_test

    task automatic reset_model();
        for (int a = 0; a < 8; a++) begin
            model[a] = field_mask(a) & 16'h4444;
        end
    endtask : reset_model

    task automatic report_and_stop();
        if (miscompares == 0 && checks_done > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : report_and_stop

    // Ceiling well above the roughly 1600 cycles the run needs
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            report_and_stop();
        end
    end

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        nrst = 1'b0;
        addr = 3'h0;
        wdata = 16'h0000;
        wr = 1'b0;
        rd = 1'b0;
        src_req = 10'h000;
        miscompares = 0;
        checks_done = 0;
        cycles = 0;
        void'($urandom(32'h9df90f37));
        reset_model();
        repeat (5) @(posedge clk);
        nrst <= 1'b1;
        check_all();
        // All ones, all zeros, then random words, unmapped indices too
        for (int n = 0; n < 40; n++) begin
            for (int a = 0; a < 8; a++) begin
                d = (n == 0) ? 16'hffff : (n == 1) ? 16'h0000 : 16'($urandom);
                wr_reg(a[2:0], d);
                model[a] = d & field_mask(a);
            end
            check_all();
            gate_test(10'($urandom));
            gate_test(10'h3ff);
            gate_test(10'h001);
        end
        // Reset in mid-run brings every field back to level four
        @(posedge clk);
        nrst    <= 1'b0;
        src_req <= 10'h000;
        @(posedge clk);
        nrst <= 1'b1;
        reset_model();
        check_all();
        gate_test(10'h2a5);
        report_and_stop();
    end

endmodule : ipcb_bank_test

/* File: verilog/ipcb_bank.sv */
// Interrupt priority configuration bank: ten 3-bit priority fields.
// Assumes a single-cycle register port master and raw source requests.
//
// Overview of operation
// - Fields 1 to 7 are levels, 7 highest
// - Zero field disables the source request
// - Unused bits ignore writes, read zero
// - Parallel port priority at bits 6-4
// - I2C2 master 10-8, slave 6-4
// - CRC 14-12, UART2 10-8, UART1 6-4
// - Every field resets to level four
//
// Design decisions made here: the address map and the address-and-strobe port.
`timescale 1ns/1ps
`include "ipcb_map.svh"

module ipcb_bank #(
    parameter int NSRC = 10
) (
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              nrst,
    // Register port
    input  wire logic [2:0]        addr,
    input  wire logic [15:0]       wdata,
    input  wire logic              wr,
    input  wire logic              rd,
    output logic      [15:0]       rdata,
    // Source requests, order as in the priority bundle
    input  wire logic [NSRC-1:0]   src_req,
    // Priorities and gated requests
    output ipcb_pkg::ipcb_prio_s   prio,
    output logic      [NSRC-1:0]   req_out,
    output logic      [2:0]        top_level
);

    // ****************************************************************
    // Priority fields
    // ****************************************************************
    ipcb_pkg::ipcb_prio_s prio_reg;
    logic [15:0]          rdata_reg;
    logic [15:0]          rdata_next;
    logic [NSRC-1:0]      req_reg;
    logic [2:0]           top_reg;
    logic [2:0]           top_next;
    logic [NSRC*3-1:0]    prio_flat;

    assign prio_flat = prio_reg;

    // Only the documented field bits are stored; others never exist
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            prio_reg <= {NSRC{`IPCB_PRIO_RESET}};
        end else if (wr) begin
            if (addr == `IPCB_ADDR_CAPTURE_3_4) begin
                prio_reg.capture_four_prio <=
                    wdata[`IPCB_POS_MID +: `IPCB_PRIO_W];
                prio_reg.capture_three_prio <=
                    wdata[`IPCB_POS_LOW +: `IPCB_PRIO_W];
            end else if (addr == `IPCB_ADDR_COMPARE_5) begin
                prio_reg.compare_five_prio <=
                    wdata[`IPCB_POS_LOW +: `IPCB_PRIO_W];
            end else if (addr == `IPCB_ADDR_PARALLEL_PORT) begin
                prio_reg.parallel_port_prio <=
                    wdata[`IPCB_POS_LOW +: `IPCB_PRIO_W];
            end else if (addr == `IPCB_ADDR_SECOND_I2C) begin
                prio_reg.second_i2c_master_prio <=
                    wdata[`IPCB_POS_MID +: `IPCB_PRIO_W];
                prio_reg.second_i2c_slave_prio <=
                    wdata[`IPCB_POS_LOW +: `IPCB_PRIO_W];
            end else if (addr == `IPCB_ADDR_CALENDAR) begin
                prio_reg.calendar_prio <=
                    wdata[`IPCB_POS_MID +: `IPCB_PRIO_W];
            end else if (addr == `IPCB_ADDR_CRC_UART) begin
                prio_reg.checksum_error_prio <=
                    wdata[`IPCB_POS_HIGH +: `IPCB_PRIO_W];
                prio_reg.second_uart_error_prio <=
                    wdata[`IPCB_POS_MID +: `IPCB_PRIO_W];
                prio_reg.first_uart_error_prio <=
                    wdata[`IPCB_POS_LOW +: `IPCB_PRIO_W];
            end
        end
    end

    // ****************************************************************
    // Read path
    // ****************************************************************
    always_comb begin
        rdata_next = 16'h0000;
        if (addr == `IPCB_ADDR_CAPTURE_3_4) begin
            rdata_next[`IPCB_POS_MID +: `IPCB_PRIO_W] =
                prio_reg.capture_four_prio;
            rdata_next[`IPCB_POS_LOW +: `IPCB_PRIO_W] =
                prio_reg.capture_three_prio;
        end else if (addr == `IPCB_ADDR_COMPARE_5) begin
            rdata_next[`IPCB_POS_LOW +: `IPCB_PRIO_W] =
                prio_reg.compare_five_prio;
        end else if (addr == `IPCB_ADDR_PARALLEL_PORT) begin
            rdata_next[`IPCB_POS_LOW +: `IPCB_PRIO_W] =
                prio_reg.parallel_port_prio;
        end else if (addr == `IPCB_ADDR_SECOND_I2C) begin
            rdata_next[`IPCB_POS_MID +: `IPCB_PRIO_W] =
                prio_reg.second_i2c_master_prio;
            rdata_next[`IPCB_POS_LOW +: `IPCB_PRIO_W] =
                prio_reg.second_i2c_slave_prio;
        end else if (addr == `IPCB_ADDR_CALENDAR) begin
            rdata_next[`IPCB_POS_MID +: `IPCB_PRIO_W] =
                prio_reg.calendar_prio;
        end else if (addr == `IPCB_ADDR_CRC_UART) begin
            rdata_next[`IPCB_POS_HIGH +: `IPCB_PRIO_W] =
                prio_reg.checksum_error_prio;
            rdata_next[`IPCB_POS_MID +: `IPCB_PRIO_W] =
                prio_reg.second_uart_error_prio;
            rdata_next[`IPCB_POS_LOW +: `IPCB_PRIO_W] =
                prio_reg.first_uart_error_prio;
        end
    end

    // Read data stands one cycle only, zero otherwise
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rdata_reg <= 16'h0000;
        end else if (rd) begin
            rdata_reg <= rdata_next;
        end else begin
            rdata_reg <= 16'h0000;
        end
    end

    // ****************************************************************
    // Request gating and top level
    // ****************************************************************
    // Highest level wins; ties keep the lower source index
    always_comb begin
        top_next = `IPCB_PRIO_OFF;
        for (int i = 0; i < NSRC; i++) begin
            if (src_req[i] && prio_flat[i*3 +: 3] > top_next) begin
                top_next = prio_flat[i*3 +: 3];
            end
        end
    end

    genvar g;
    generate
        for (g = 0; g < NSRC; g++) begin : g_gate
            always_ff @(posedge clk or negedge nrst) begin
                if (!nrst) begin
                    req_reg[g] <= 1'b0;
                end else begin
                    req_reg[g] <= src_req[g] &&
                        (prio_flat[g*3 +: 3] != `IPCB_PRIO_OFF);
                end
            end
            chk_gate_off: assert property (
                @(posedge clk) disable iff (!nrst)
                (prio_flat[g*3 +: 3] == `IPCB_PRIO_OFF) |=> !req_out[g])
                else $error("disabled source passed the gate");
            chk_gate_on: assert property (
                @(posedge clk) disable iff (!nrst)
                (src_req[g] && prio_flat[g*3 +: 3] != `IPCB_PRIO_OFF)
                    |=> req_out[g])
                else $error("enabled source blocked at the gate");
            chk_top_covers: assert property (
                @(posedge clk) disable iff (!nrst)
                (src_req[g] && prio_flat[g*3 +: 3] != `IPCB_PRIO_OFF)
                    |=> top_level >= $past(prio_flat[g*3 +: 3]))
                else $error("top level below a requesting source");
        end
    endgenerate

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            top_reg <= `IPCB_PRIO_OFF;
        end else begin
            top_reg <= top_next;
        end
    end

    assign rdata     = rdata_reg;
    assign prio      = prio_reg;
    assign req_out   = req_reg;
    assign top_level = top_reg;

    // ****************************************************************
    // Checks
    // ****************************************************************
    chk_disabled_no_req: assert property (
        @(posedge clk) disable iff (!nrst)
        ##1 ($past(prio_flat[2:0]) == 3'h0) |-> !req_out[0])
        else $error("disabled source presented");
    chk_enabled_req: assert property (
        @(posedge clk) disable iff (!nrst)
        (src_req[0] && prio_flat[2:0] != 3'h0) |=> req_out[0])
        else $error("enabled source lost");
    chk_top_level: assert property (
        @(posedge clk) disable iff (!nrst)
        (src_req == 10'h001 && prio_flat[2:0] == 3'h7)
            |=> top_level == 3'h7)
        else $error("top level wrong");
    chk_idle_level: assert property (
        @(posedge clk) disable iff (!nrst)
        (src_req == 10'h000) |=> top_level == 3'h0)
        else $error("top level without request");
    chk_pp_write: assert property (
        @(posedge clk) disable iff (!nrst)
        (wr && addr == 3'h2) |=> prio.parallel_port_prio == $past(wdata[6:4]))
        else $error("parallel port field write");
    chk_i2c_read: assert property (
        @(posedge clk) disable iff (!nrst)
        (rd && addr == 3'h3) |=> rdata == {5'h00,
            $past(prio.second_i2c_master_prio), 1'b0,
            $past(prio.second_i2c_slave_prio), 4'h0})
        else $error("i2c register read");
    chk_crc_write: assert property (
        @(posedge clk) disable iff (!nrst)
        (wr && addr == 3'h5) |=> (prio.checksum_error_prio ==
            $past(wdata[14:12]) && prio.first_uart_error_prio ==
            $past(wdata[6:4])))
        else $error("crc register write");
    chk_reserved_zero: assert property (
        @(posedge clk) disable iff (!nrst)
        ##1 (rdata[15] | rdata[11] | rdata[7] | (|rdata[3:0])) == 1'b0)
        else $error("reserved bits nonzero");
    chk_cal_read: assert property (
        @(posedge clk) disable iff (!nrst)
        (rd && addr == 3'h4) |=> rdata[10:8] == $past(prio.calendar_prio))
        else $error("calendar read");
    chk_reset_value: assert property (
        @(posedge clk) $rose(nrst) |-> prio == {NSRC{`IPCB_PRIO_RESET}})
        else $error("reset value wrong");
    chk_cap_write: assert property (
        @(posedge clk) disable iff (!nrst)
        (wr && addr == `IPCB_ADDR_CAPTURE_3_4) |=>
            (prio.capture_four_prio == $past(wdata[10:8]) &&
            prio.capture_three_prio == $past(wdata[6:4])))
        else $error("capture register write");
    chk_cmp_write: assert property (
        @(posedge clk) disable iff (!nrst)
        (wr && addr == `IPCB_ADDR_COMPARE_5) |=>
            prio.compare_five_prio == $past(wdata[6:4]))
        else $error("compare register write");
    chk_i2c_write: assert property (
        @(posedge clk) disable iff (!nrst)
        (wr && addr == `IPCB_ADDR_SECOND_I2C) |=>
            (prio.second_i2c_master_prio == $past(wdata[10:8]) &&
            prio.second_i2c_slave_prio == $past(wdata[6:4])))
        else $error("i2c register write");
    chk_cal_write: assert property (
        @(posedge clk) disable iff (!nrst)
        (wr && addr == `IPCB_ADDR_CALENDAR) |=>
            prio.calendar_prio == $past(wdata[10:8]))
        else $error("calendar register write");
    chk_uart2_write: assert property (
        @(posedge clk) disable iff (!nrst)
        (wr && addr == `IPCB_ADDR_CRC_UART) |=>
            prio.second_uart_error_prio == $past(wdata[10:8]))
        else $error("uart2 field write");
    // Unmapped indices and idle cycles must leave every field alone
    chk_unmapped_write: assert property (
        @(posedge clk) disable iff (!nrst)
        (addr > `IPCB_ADDR_CRC_UART || !wr) |=> $stable(prio))
        else $error("field changed without a mapped write");
    chk_cap_read: assert property (
        @(posedge clk) disable iff (!nrst)
        (rd && addr == `IPCB_ADDR_CAPTURE_3_4) |=> rdata == {5'h00,
            $past(prio.capture_four_prio), 1'b0,
            $past(prio.capture_three_prio), 4'h0})
        else $error("capture register read");
    chk_cmp_read: assert property (
        @(posedge clk) disable iff (!nrst)
        (rd && addr == `IPCB_ADDR_COMPARE_5) |=> rdata == {9'h000,
            $past(prio.compare_five_prio), 4'h0})
        else $error("compare register read");
    chk_pp_read: assert property (
        @(posedge clk) disable iff (!nrst)
        (rd && addr == `IPCB_ADDR_PARALLEL_PORT) |=> rdata == {9'h000,
            $past(prio.parallel_port_prio), 4'h0})
        else $error("parallel port register read");
    chk_crc_read: assert property (
        @(posedge clk) disable iff (!nrst)
        (rd && addr == `IPCB_ADDR_CRC_UART) |=> rdata == {1'b0,
            $past(prio.checksum_error_prio), 1'b0,
            $past(prio.second_uart_error_prio), 1'b0,
            $past(prio.first_uart_error_prio), 4'h0})
        else $error("crc register read");
    // Any read outside the map, and every idle cycle, shows zero
    chk_unmapped_read: assert property (
        @(posedge clk) disable iff (!nrst)
        (!rd || addr > `IPCB_ADDR_CRC_UART) |=> rdata == 16'h0000)
        else $error("read data outside a mapped read");
    // Top level only ever reports a request that passed the gate
    chk_top_backed: assert property (
        @(posedge clk) disable iff (!nrst)
        (top_level != `IPCB_PRIO_OFF) |-> (|req_out))
        else $error("top level without gated request");

    cov_write_crc: cover property (@(posedge clk) wr && addr == 3'h5);
    cov_read_cap: cover property (@(posedge clk) rd && addr == 3'h0);
    cov_disable: cover property (@(posedge clk)
        src_req[0] && prio_flat[2:0] == 3'h0);
    cov_top7: cover property (@(posedge clk) top_level == 3'h7);
    cov_unmapped_rd: cover property (@(posedge clk)
        rd && addr > `IPCB_ADDR_CRC_UART);

endmodule : ipcb_bank

/* File: verilog/ipcb_map.svh */
// Register offsets, field positions, reset values of the priority bank.
// Assumes a 16-bit register bus with word indices 0 to 5.
`ifndef IPCB_MAP_SVH
`define IPCB_MAP_SVH

// ****************************************************************
// Register indices
// ****************************************************************
`define IPCB_ADDR_CAPTURE_3_4   3'h0
`define IPCB_ADDR_COMPARE_5     3'h1
`define IPCB_ADDR_PARALLEL_PORT 3'h2
`define IPCB_ADDR_SECOND_I2C    3'h3
`define IPCB_ADDR_CALENDAR      3'h4
`define IPCB_ADDR_CRC_UART      3'h5

// ****************************************************************
// Field low bit positions
// ****************************************************************
`define IPCB_POS_HIGH 12
`define IPCB_POS_MID  8
`define IPCB_POS_LOW  4

// ****************************************************************
// Reset value and field width
// ****************************************************************
`define IPCB_PRIO_RESET 3'h4
`define IPCB_PRIO_OFF   3'h0
`define IPCB_PRIO_W     3

`endif

/* File: verilog/ipcb_pkg.sv */
// Types shared by the priority bank and its users.
// Assumes ipcb_map.svh is compiled alongside.
package ipcb_pkg;

    typedef logic [2:0] ipcb_prio_t;

    // Per-source priorities, carried as one bundle
    typedef struct packed {
        ipcb_prio_t capture_four_prio;
        ipcb_prio_t capture_three_prio;
        ipcb_prio_t compare_five_prio;
        ipcb_prio_t parallel_port_prio;
        ipcb_prio_t second_i2c_master_prio;
        ipcb_prio_t second_i2c_slave_prio;
        ipcb_prio_t calendar_prio;
        ipcb_prio_t checksum_error_prio;
        ipcb_prio_t second_uart_error_prio;
        ipcb_prio_t first_uart_error_prio;
    } ipcb_prio_s;

endpackage : ipcb_pkg
